// File: logic/afsw_pkg.sv
// Shared constants and carrier types for the sixteen-word store
package afsw_pkg;
	localparam int AFSW_DEPTH = 16;
	localparam int AFSW_NARROW_W = 4;
	localparam int AFSW_WIDE_W = 5;
	localparam int AFSW_MAX_W = 5;
	localparam int AFSW_LVL_W = 5;
	localparam int AFSW_ALMOST_FULL_LVL = 15;
	localparam int AFSW_ALMOST_EMPTY_LVL = 1;
	localparam int AFSW_SYNC_STAGES = 2;
	localparam int AFSW_MCLK_MHZ = 20;
	localparam int AFSW_STROBE_MAX_MHZ = 30;

	// Pin group sampled from outside the clock domain
	typedef struct packed {
		logic rst_n;
		logic load_strobe;
		logic unload_strobe;
		logic oe;
		logic [AFSW_MAX_W-1:0] data;
	} afsw_pins_t;

	// Active-low status flags
	typedef struct packed {
		logic full_n;
		logic empty_n;
		logic almost_full_n;
		logic almost_empty_n;
	} afsw_flags_t;

	localparam afsw_flags_t AFSW_FLAGS_RST = '{
		full_n: 1'b1,
		empty_n: 1'b0,
		almost_full_n: 1'b1,
		almost_empty_n: 1'b1
	};

	// Whole state of the top module
	typedef struct packed {
		afsw_pins_t s1;
		afsw_pins_t s2;
		logic load_prev;
		logic unload_prev;
		afsw_flags_t flags;
	} afsw_top_state_t;

	localparam afsw_top_state_t AFSW_TOP_RST = '{
		s1: '0,
		s2: '0,
		load_prev: 1'b0,
		unload_prev: 1'b0,
		flags: AFSW_FLAGS_RST
	};
endpackage : afsw_pkg

// File: logic/afsw_fifo.sv
// Parameterised word store with registered fall-through head
`timescale 1ns/1ns
`default_nettype none
module afsw_fifo #(
	parameter int W = 5,
	parameter int DEPTH = 16,
	parameter int LVL_W = 5
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_clear,
	// Fill side
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	input wire logic [W-1:0] i_wr_data,
	// Drain side
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [W-1:0] o_rd_data,
	// Occupancy
	output logic [LVL_W-1:0] o_level,
	output logic [LVL_W-1:0] o_level_nxt
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [LVL_W-1:0] level;
	} afsw_fifo_state_t;

	afsw_fifo_state_t st_r;
	afsw_fifo_state_t st_nxt;
	logic [W-1:0] rd_data_r;
	logic push;
	logic pop;

	assign o_wr_ready = (st_r.level != LVL_FULL);
	assign o_rd_valid = (st_r.level != '0);
	assign push = i_wr_valid & o_wr_ready;
	assign pop = i_rd_ready & o_rd_valid;
	assign o_level = st_r.level;
	assign o_level_nxt = st_nxt.level;
	assign o_rd_data = rd_data_r;

	always_comb
	begin
		st_nxt = st_r;
		if (i_clear)
		begin
			st_nxt.wr_ptr = '0;
			st_nxt.rd_ptr = '0;
			st_nxt.level = '0;
		end
		else
		begin
			if (push)
			begin
				st_nxt.mem[st_r.wr_ptr] = i_wr_data;
				st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
			end
			if (pop)
				st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
			if (push && !pop)
				st_nxt.level = st_r.level + 1'b1;
			else if (pop && !push)
				st_nxt.level = st_r.level - 1'b1;
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// Head word register, never reset; held through clear and while empty
	always_ff @(posedge i_mclk)
	begin
		if (i_clear)
			rd_data_r <= rd_data_r;
		else if (push && (st_r.wr_ptr == st_nxt.rd_ptr))
			rd_data_r <= i_wr_data;
		else if (st_nxt.level != '0)
			rd_data_r <= st_r.mem[st_nxt.rd_ptr];
	end
endmodule : afsw_fifo
`default_nettype wire

// File: logic/afsw_top.sv
// Sixteen-word first-in first-out store with strobe pins and flags
// Function
// - Narrow variant holds sixteen four-bit words in arrival order.
// - Wide variant holds sixteen five-bit words, adds almost-full and almost-empty flags.
// - Rising load strobe stores the presented word; writer sets data first.
// - Rising unload strobe drops the oldest word and shows the next one.
// - Store is full when sixteen more words loaded than unloaded.
// - Load strobes while full are ignored; contents stay unchanged.
// - Unload strobes while empty are ignored; pointers and flags stay.
// - Full flag low exactly while sixteen words are held.
// - Empty flag low exactly while no word is held.
// - Wide variant almost-full flag low exactly at fifteen words.
// - Wide variant almost-empty flag low exactly at one word.
// - Low reset pin clears pointers, empty low, other flags high.
// - Reset leaves the data outputs at whatever they held.
// - First load into an empty store shows its word at once.
// - Data outputs are not inverted and stay driven; enable low only raises o_q_oe_n.
// - Output enable touches only the data outputs, never the flags.
// - Data outputs count as invalid whenever occupancy is zero.
`timescale 1ns/1ns
`default_nettype none
module afsw_top #(
	parameter bit WIDE = 1'b1,
	parameter int DATA_W = WIDE ? afsw_pkg::AFSW_WIDE_W : afsw_pkg::AFSW_NARROW_W,
	parameter int DEPTH = afsw_pkg::AFSW_DEPTH,
	parameter int LVL_W = afsw_pkg::AFSW_LVL_W
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// Pins from the writer and reader
	input wire afsw_pkg::afsw_pins_t i_pins,
	// Data outputs
	output logic [DATA_W-1:0] o_q,
	output logic o_q_oe_n,
	output logic o_q_valid,
	// Status
	output afsw_pkg::afsw_flags_t o_flags,
	output logic [LVL_W-1:0] o_occupancy_count
);
	import afsw_pkg::*;

	localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);
	localparam logic [LVL_W-1:0] LVL_AF = LVL_W'(AFSW_ALMOST_FULL_LVL);
	localparam logic [LVL_W-1:0] LVL_AE = LVL_W'(AFSW_ALMOST_EMPTY_LVL);

	afsw_top_state_t st_r;
	afsw_top_state_t st_nxt;
	logic load_edge;
	logic unload_edge;
	logic clear;
	logic wr_ready;
	logic rd_valid;
	logic [DATA_W-1:0] wr_data;
	logic [DATA_W-1:0] rd_data;
	logic [LVL_W-1:0] level;
	logic [LVL_W-1:0] level_nxt;

	// Edges seen only past the second synchroniser stage
	assign clear = ~st_r.s2.rst_n;
	assign load_edge = st_r.s2.load_strobe & ~st_r.load_prev & ~clear;
	assign unload_edge = st_r.s2.unload_strobe & ~st_r.unload_prev & ~clear;
	assign wr_data = st_r.s2.data[DATA_W-1:0];

	// Ignored strobes: full refuses fill, empty refuses drain
	afsw_fifo #(
		.W(DATA_W),
		.DEPTH(DEPTH),
		.LVL_W(LVL_W)
	) u_store (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.i_clear(clear),
		.i_wr_valid(load_edge),
		.o_wr_ready(wr_ready),
		.i_wr_data(wr_data),
		.o_rd_valid(rd_valid),
		.i_rd_ready(unload_edge),
		.o_rd_data(rd_data),
		.o_level(level),
		.o_level_nxt(level_nxt)
	);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = i_pins;
		st_nxt.s2 = st_r.s1;
		st_nxt.load_prev = st_r.s2.load_strobe;
		st_nxt.unload_prev = st_r.s2.unload_strobe;
		// Flags registered from next occupancy
		st_nxt.flags.full_n = (level_nxt != LVL_FULL);
		st_nxt.flags.empty_n = (level_nxt != '0);
		st_nxt.flags.almost_full_n = !(WIDE && (level_nxt == LVL_AF));
		st_nxt.flags.almost_empty_n = !(WIDE && (level_nxt == LVL_AE));
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			st_r <= AFSW_TOP_RST;
		else
			st_r <= st_nxt;
	end

	assign o_q = rd_data;
	assign o_q_oe_n = ~st_r.s2.oe;
	assign o_q_valid = st_r.flags.empty_n;
	assign o_flags = st_r.flags;
	assign o_occupancy_count = level;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);

	property p_load_stores;
		load_edge && wr_ready && !unload_edge |=> level == LVL_W'($past(level) + 1'b1);
	endproperty
	a_load_stores: assert property (p_load_stores) else $error("load did not add a word");

	property p_unload_pops;
		unload_edge && rd_valid && !load_edge |=> level == LVL_W'($past(level) - 1'b1);
	endproperty
	a_unload_pops: assert property (p_unload_pops) else $error("unload did not drop a word");

	property p_full_ignores;
		load_edge && !wr_ready && !unload_edge && !clear |=> $stable(level) && !o_flags.full_n;
	endproperty
	a_full_ignores: assert property (p_full_ignores) else $error("load while full took effect");

	property p_empty_ignores;
		unload_edge && !rd_valid && !load_edge |=> level == '0 && !o_flags.empty_n;
	endproperty
	a_empty_ignores: assert property (p_empty_ignores) else $error("unload while empty took effect");

	property p_full_flag;
		o_flags.full_n == (level != LVL_FULL);
	endproperty
	a_full_flag: assert property (p_full_flag) else $error("full flag disagrees with count");

	property p_empty_flag;
		o_q_valid == (level != '0);
	endproperty
	a_empty_flag: assert property (p_empty_flag) else $error("empty flag disagrees with count");

	property p_almost_flags;
		(o_flags.almost_full_n == !(WIDE && level == LVL_AF))
			&& (o_flags.almost_empty_n == !(WIDE && level == LVL_AE));
	endproperty
	a_almost_flags: assert property (p_almost_flags) else $error("almost flag wrong");

	property p_fall_through;
		load_edge && level == '0 && !clear |=> o_q_valid && o_q == $past(wr_data);
	endproperty
	a_fall_through: assert property (p_fall_through) else $error("first word did not show");

	property p_oe_only_data;
		!$past(i_sys_rst, 2) |-> o_q_oe_n == !$past(i_pins.oe, 2);
	endproperty
	a_oe_only_data: assert property (p_oe_only_data) else $error("output enable path wrong");

	property p_reset_pin;
		clear |=> level == '0 && !o_flags.empty_n && o_flags.full_n
			&& o_flags.almost_full_n && o_flags.almost_empty_n;
	endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("reset pin did not clear");

	c_full: cover property (level == LVL_FULL);
	c_load_when_full: cover property (load_edge && !wr_ready);
	c_unload_when_empty: cover property (unload_edge && !rd_valid);
	c_both_strobes: cover property (load_edge && unload_edge && rd_valid);
endmodule : afsw_top
`default_nettype wire

// File: verification/afsw_host_model.sv
// Writer and reader agent strobing words into and out of the store
`timescale 1ns/1ns
`default_nettype none
module afsw_host_model (
	// Clock
	input wire logic i_mclk,
	// Pins toward the store
	output var afsw_pkg::afsw_pins_t o_pins
);
	import afsw_pkg::*;

	initial
	begin
		o_pins = '0;
		o_pins.rst_n = 1'b1;
		o_pins.oe = 1'b1;
	end

	// One load and or unload strobe pulse
	task automatic step(input logic ld, input logic ul, input logic [4:0] d);
		@(posedge i_mclk);
		o_pins.data <= d;
		@(posedge i_mclk);
		o_pins.load_strobe <= ld;
		o_pins.unload_strobe <= ul;
		repeat (3) @(posedge i_mclk);
		o_pins.load_strobe <= 1'b0;
		o_pins.unload_strobe <= 1'b0;
		o_pins.data <= ~d;
		repeat (3) @(posedge i_mclk);
		#1;
	endtask : step

	// Output enable level
	task automatic set_oe(input logic v);
		@(posedge i_mclk);
		o_pins.oe <= v;
		repeat (3) @(posedge i_mclk);
		#1;
	endtask : set_oe

	// Device reset pin level
	task automatic set_rst(input logic v);
		@(posedge i_mclk);
		o_pins.rst_n <= v;
		repeat (4) @(posedge i_mclk);
		#1;
	endtask : set_rst
endmodule : afsw_host_model
`default_nettype wire

// File: verification/afsw_top_tb_top.sv
// Self-checking bench for the sixteen-word store
`timescale 1ns/1ns
`default_nettype none
module afsw_top_tb_top;
	import afsw_pkg::*;
	logic i_mclk;
	logic i_sys_rst;
	afsw_pins_t pins;
	logic [4:0] q;
	logic q_oe_n;
	logic q_valid;
	afsw_flags_t flags;
	logic [4:0] cnt;
	logic [3:0] q_n;
	afsw_flags_t flags_n;
	logic [4:0] cnt_n;
	int err_count;
	int n_tests;

	afsw_top #(.WIDE(1'b1)) dut (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.i_pins(pins),
		.o_q(q),
		.o_q_oe_n(q_oe_n),
		.o_q_valid(q_valid),
		.o_flags(flags),
		.o_occupancy_count(cnt)
	);

	afsw_top #(.WIDE(1'b0)) dut_narrow (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.i_pins(pins),
		.o_q(q_n),
		.o_q_oe_n(),
		.o_q_valid(),
		.o_flags(flags_n),
		.o_occupancy_count(cnt_n)
	);

	afsw_host_model host (
		.i_mclk(i_mclk),
		.o_pins(pins)
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Count and flags for n words held
	task automatic lvl(input int n);
		chk(8'(cnt), 8'(n));
		chk(8'(flags.full_n), 8'(n != 16));
		chk(8'(flags.empty_n), 8'(n != 0));
		chk(8'(flags.almost_full_n), 8'(n != 15));
		chk(8'(flags.almost_empty_n), 8'(n != 1));
		chk(8'(q_valid), 8'(n != 0));
		chk(8'(cnt_n), 8'(n));
		chk(8'(flags_n), 8'({n != 16, n != 0, 2'b11}));
	endtask : lvl

	// Head word on both variants
	task automatic head(input logic [4:0] v);
		chk(8'(q), 8'(v));
		chk(8'(q_n), 8'(v[3:0]));
	endtask : head

	task automatic close_out();
		if (err_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	initial
	begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	initial
	begin
		#(50 * 3000);
		err_count++;
		close_out();
	end

	initial
	begin
		i_sys_rst = 1'b1;
		err_count = 0;
		n_tests = 0;
		repeat (10) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		repeat (3) @(posedge i_mclk);
		#1;
		lvl(0);
		chk(8'(q_oe_n), 8'h00);
		for (int i = 0; i < 16; i++)
		begin
			chk(8'(flags.full_n), 8'h01);
			host.step(1'b1, 1'b0, 5'(i * 7 + 3));
			lvl(i + 1);
			head(5'h03);
		end
		host.step(1'b1, 1'b0, 5'h1F);
		lvl(16);
		host.set_oe(1'b0);
		chk(8'(q_oe_n), 8'h01);
		lvl(16);
		host.set_oe(1'b1);
		host.step(1'b1, 1'b1, 5'h1E);
		lvl(15);
		for (int i = 1; i < 16; i++)
		begin
			head(5'(i * 7 + 3));
			chk(8'(flags.empty_n), 8'h01);
			host.step(1'b0, 1'b1, 5'h00);
			lvl(15 - i);
		end
		chk(8'(q_valid), 8'h00);
		host.step(1'b0, 1'b1, 5'h00);
		lvl(0);
		host.step(1'b1, 1'b1, 5'h15);
		lvl(1);
		head(5'h15);
		host.step(1'b1, 1'b0, 5'h0C);
		host.step(1'b0, 1'b1, 5'h00);
		lvl(1);
		head(5'h0C);
		host.set_rst(1'b0);
		lvl(0);
		head(5'h0C);
		host.set_rst(1'b1);
		close_out();
	end
endmodule : afsw_top_tb_top
`default_nettype wire
